// *** rtl/csl_clamp_logic.sv ***
// Clamp, pneumatic, trim, home and thread sensor sequencing logic
// Summary of operation
// R01 - Each step-on activation switches on the next clamp, one to four; step-on stops at the effective clamp count
// R02 - Step-on is ignored while effective clamp count is one
// R03 - Each step-off activation switches off the highest clamp, four to one
// R04 - Step-off is ignored while effective clamp count is one
// R05 - Clamp clear switches all clamps off at once
// R06 - Pneumatic step only acts while two-step enable is set
// R07 - Pneumatic step cycles low, high, third outputs, then repeats
// R08 - Each toggle input flips its own clamp, clamps one to four
// R09 - Per-clamp inhibit keeps that clamp from turning on
// R10 - All-clamp inhibit keeps every clamp from turning on
// R11 - Wiper cancel suppresses the wiper output
// R12 - Trim cancel suppresses trim, release and wiper outputs
// R13 - Trim protect stops a running machine, resumes when released
// R14 - Trim protect during trimming stops only after trimming completes
// R15 - Home inhibit refuses home requests from key or input
// R16 - Thread sensor detects breakage only while sensor setting enabled
// R17 - With priority, toggle two to four need preceding clamp on
// R18 - Activation is the rising edge; a held input acts once; clamp clear acts on its level, every cycle it is held
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csl_consts.svh"

module csl_clamp_logic (
    // Clock, enable and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Switch and sequencer inputs
    input wire csl_pkg::csl_sw_t sw_in,
    input wire csl_pkg::csl_seq_t seq_in,
    // Actuators and machine control
    output csl_pkg::csl_act_t act_out,
    output logic run_enable,
    output logic home_go,
    output logic thread_break,
    output logic irq
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [2:0] first_off(input logic [3:0] v);
        logic [2:0] idx;
        idx = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (!v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [2:0] last_on(input logic [3:0] v);
        logic [2:0] idx;
        idx = 3'h4;
        for (int i = 0; i < 4; i++) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [2:0] eff_count(input logic [2:0] c);
        logic [2:0] n;
        n = c;
        if (c == 3'h0 || c > 3'h4) begin
            n = 3'h4;
        end
        return n;
    endfunction

    // ****************************************
    // Registers and edge detection
    // ****************************************
    logic [5:0] ctrl_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic ack_r;
    logic [31:0] dat_r;
    csl_pkg::csl_sw_t prev_r;
    csl_pkg::csl_sw_t rise;
    logic [3:0] clamp_r;
    logic [3:0] clamp_nxt;
    csl_pkg::csl_pn_state_t pn_r;
    csl_pkg::csl_pn_state_t pn_nxt;
    logic run_r;
    logic home_r;
    logic thread_r;
    logic home_refused;
    logic protect_stop;
    logic [2:0] count;
    logic [2:0] on_idx;
    logic [2:0] off_idx;
    logic [3:0] blocked;
    logic [2:0] irq_event;
    logic bus_req;
    logic bus_wr;

    assign count = eff_count(ctrl_r[`CSL_CTRL_COUNT_MSB:`CSL_CTRL_COUNT_LSB]);
    assign rise = sw_in & ~prev_r; // R18

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_r <= '0;
        end else if (ce) begin
            prev_r <= sw_in; // R18
        end
    end

    // ****************************************
    // Clamp outputs
    // ****************************************
    assign blocked = sw_in.clamp_inhibit_inputs | {4{sw_in.all_clamp_inhibit_input}}; // R09 R10
    assign on_idx = first_off(clamp_r);
    assign off_idx = last_on(clamp_r);

    always_comb begin
        clamp_nxt = clamp_r;
        if (rise.clamp_step_on_input && count != 3'h1 && on_idx < count) begin // R01 R02
            clamp_nxt[on_idx[1:0]] = 1'b1; // R01
        end
        if (rise.clamp_step_off_input && count != 3'h1 && off_idx != 3'h4) begin // R03 R04
            clamp_nxt[off_idx[1:0]] = 1'b0; // R03
        end
        for (int i = 0; i < 4; i++) begin
            if (rise.clamp_toggle_inputs[i]) begin
                if (i == 0 || !ctrl_r[`CSL_CTRL_PRIO_BIT] || clamp_r[(i + 3) % 4]) begin // R17
                    clamp_nxt[i] = ~clamp_r[i]; // R08
                end
            end
        end
        clamp_nxt = clamp_nxt & ~(blocked & ~clamp_r); // R09 R10
        if (sw_in.clamp_clear_input) begin
            clamp_nxt = 4'h0; // R05
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            clamp_r <= 4'h0;
        end else if (ce) begin
            clamp_r <= clamp_nxt;
        end
    end

    // ****************************************
    // Pneumatic three-step clamp
    // ****************************************
    always_comb begin
        pn_nxt = pn_r;
        if (rise.pneumatic_step_input && ctrl_r[`CSL_CTRL_PN2_BIT]) begin // R06
            unique case (pn_r)
                csl_pkg::CSL_PN_IDLE: pn_nxt = csl_pkg::CSL_PN_LOW; // R07
                csl_pkg::CSL_PN_LOW: pn_nxt = csl_pkg::CSL_PN_HIGH; // R07
                csl_pkg::CSL_PN_HIGH: pn_nxt = csl_pkg::CSL_PN_THIRD; // R07
                csl_pkg::CSL_PN_THIRD: pn_nxt = csl_pkg::CSL_PN_LOW; // R07
                default: pn_nxt = csl_pkg::CSL_PN_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pn_r <= csl_pkg::CSL_PN_IDLE;
        end else if (ce) begin
            pn_r <= pn_nxt;
        end
    end

    // ****************************************
    // Actuator output register
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            act_out <= '0;
        end else if (ce) begin
            act_out.clamp_outputs <= clamp_nxt;
            act_out.pneumatic_low_output <= pn_nxt == csl_pkg::CSL_PN_LOW;
            act_out.pneumatic_high_output <= pn_nxt == csl_pkg::CSL_PN_HIGH;
            act_out.pneumatic_third_output <= pn_nxt == csl_pkg::CSL_PN_THIRD;
            act_out.trim_output <= seq_in.trim_req && !sw_in.trim_cancel_input; // R12
            act_out.release_output <= seq_in.release_req && !sw_in.trim_cancel_input; // R12
            act_out.wiper_output <= seq_in.wiper_req && !sw_in.trim_cancel_input
                && !sw_in.wiper_cancel_input; // R11 R12
        end
    end

    // ****************************************
    // Trim protection, home return, thread sensor
    // ****************************************
    assign protect_stop = sw_in.trim_protect_input && !seq_in.trimming; // R13 R14
    assign home_refused = (rise.home_key_input || rise.home_return_input) && sw_in.home_inhibit_input; // R15

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_r <= 1'b1;
        end else if (ce) begin
            run_r <= !protect_stop; // R13 R14
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            home_r <= 1'b0;
        end else if (ce) begin
            home_r <= (rise.home_key_input || rise.home_return_input) && !sw_in.home_inhibit_input; // R15
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            thread_r <= 1'b0;
        end else if (ce) begin
            thread_r <= sw_in.needle_thread_sensor_input && ctrl_r[`CSL_CTRL_THS_BIT]; // R16
        end
    end

    assign run_enable = run_r;
    assign home_go = home_r;
    assign thread_break = thread_r;

    // ****************************************
    // Wishbone slave
    // ****************************************
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else if (ce) begin
            ack_r <= bus_req;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `CSL_CTRL_RESET;
        end else if (ce && bus_wr && wb_adr_i == `CSL_OFS_CTRL) begin
            ctrl_r <= wb_dat_i[5:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_r <= `CSL_IRQ_RESET;
        end else if (ce && bus_wr && wb_adr_i == `CSL_OFS_IRQ_MASK) begin
            irq_mask_r <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dat_r <= 32'h0;
        end else if (ce && bus_req) begin
            dat_r <= 32'h0;
            if (!wb_we_i) begin
                unique case (wb_adr_i)
                    `CSL_OFS_CTRL: dat_r <= {26'h0, ctrl_r};
                    `CSL_OFS_STATUS: dat_r <= {23'h0, run_r, pn_r, clamp_r};
                    `CSL_OFS_IRQ_STAT: dat_r <= {29'h0, irq_stat_r};
                    `CSL_OFS_IRQ_MASK: dat_r <= {29'h0, irq_mask_r};
                    default: dat_r <= 32'h0;
                endcase
            end
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_event = {protect_stop && run_r, home_refused,
        sw_in.needle_thread_sensor_input && ctrl_r[`CSL_CTRL_THS_BIT] && !thread_r};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_r <= `CSL_IRQ_RESET;
        end else if (ce) begin
            if (bus_wr && wb_adr_i == `CSL_OFS_IRQ_STAT) begin
                irq_stat_r <= (irq_stat_r & ~wb_dat_i[2:0]) | irq_event;
            end else begin
                irq_stat_r <= irq_stat_r | irq_event;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // Assertions
    // ****************************************
    a_step_on_next: assert property (@(posedge core_clk) disable iff (!rstn) // R01
        ce && rise.clamp_step_on_input && count != 3'h1 && on_idx < count && !sw_in.clamp_clear_input
        && !blocked[on_idx[1:0]] && !rise.clamp_toggle_inputs[on_idx[1:0]]
        |=> clamp_r[$past(on_idx[1:0])])
        else $error("step-on did not set next clamp");

    a_step_count_one: assert property (@(posedge core_clk) disable iff (!rstn) // R02
        ce && count == 3'h1 && rise.clamp_toggle_inputs == 4'h0 |=> clamp_r == 4'h0 || clamp_r == $past(clamp_r)
        || $past(sw_in.clamp_clear_input))
        else $error("step input acted with count one");

    a_step_off_high: assert property (@(posedge core_clk) disable iff (!rstn) // R03
        ce && rise.clamp_step_off_input && count != 3'h1 && off_idx != 3'h4
        && !rise.clamp_toggle_inputs[off_idx[1:0]] |=> !clamp_r[$past(off_idx[1:0])])
        else $error("step-off did not clear highest clamp");

    a_clear_all: assert property (@(posedge core_clk) disable iff (!rstn) // R05
        ce && sw_in.clamp_clear_input |=> clamp_r == 4'h0 ##0 act_out.clamp_outputs == 4'h0)
        else $error("clear left a clamp on");

    a_pn_disabled: assert property (@(posedge core_clk) disable iff (!rstn) // R06
        ce && !ctrl_r[`CSL_CTRL_PN2_BIT] |=> $stable(pn_r))
        else $error("pneumatic moved while disabled");

    a_pn_cycle: assert property (@(posedge core_clk) disable iff (!rstn) // R07
        ce && rise.pneumatic_step_input && ctrl_r[`CSL_CTRL_PN2_BIT] && pn_r == csl_pkg::CSL_PN_THIRD
        |=> pn_r == csl_pkg::CSL_PN_LOW && act_out.pneumatic_low_output)
        else $error("pneumatic cycle did not wrap");

    a_inhibit_hold: assert property (@(posedge core_clk) disable iff (!rstn) // R09 R10
        ce && (blocked & ~clamp_r) != 4'h0 |=> (clamp_r & $past(blocked & ~clamp_r)) == 4'h0)
        else $error("inhibited clamp turned on");

    a_trim_cancel: assert property (@(posedge core_clk) disable iff (!rstn) // R11 R12
        ce && (sw_in.trim_cancel_input || sw_in.wiper_cancel_input) |=> !act_out.wiper_output)
        else $error("wiper not suppressed");

    a_protect_stop: assert property (@(posedge core_clk) disable iff (!rstn) // R13 R14
        ce && sw_in.trim_protect_input && seq_in.trimming |=> run_enable)
        else $error("stopped during trimming");

    a_home_refuse: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        ce && sw_in.home_inhibit_input |=> !home_go)
        else $error("home request passed while inhibited");

    a_thread_gate: assert property (@(posedge core_clk) disable iff (!rstn) // R16
        ce && !ctrl_r[`CSL_CTRL_THS_BIT] |=> !thread_break)
        else $error("thread break while sensor disabled");

    a_prio_gate: assert property (@(posedge core_clk) disable iff (!rstn) // R17
        ce && ctrl_r[`CSL_CTRL_PRIO_BIT] && !clamp_r[0] && !sw_in.clamp_step_on_input
        && !sw_in.clamp_step_off_input |=> !clamp_r[1] || $past(clamp_r[1]))
        else $error("toggle two accepted without clamp one");

    a_held_once: assert property (@(posedge core_clk) disable iff (!rstn) // R18
        ce && $past(ce) && $past(rstn) && sw_in.clamp_toggle_inputs[0] && $past(sw_in.clamp_toggle_inputs[0])
        && !sw_in.clamp_clear_input && !sw_in.clamp_step_on_input && !sw_in.clamp_step_off_input
        |=> clamp_r[0] == $past(clamp_r[0]) || !clamp_r[0] && $past(sw_in.clamp_clear_input))
        else $error("held toggle acted twice");

    a_toggle_flip: assert property (@(posedge core_clk) disable iff (!rstn) // R08
        ce && rise.clamp_toggle_inputs[0] && !blocked[0] && !sw_in.clamp_clear_input
        |=> clamp_r[0] != $past(clamp_r[0]))
        else $error("toggle one did not flip its clamp");

    a_step_off_one: assert property (@(posedge core_clk) disable iff (!rstn) // R04
        ce && count == 3'h1 && rise.clamp_step_off_input && rise.clamp_toggle_inputs == 4'h0
        && !sw_in.clamp_clear_input |=> clamp_r == $past(clamp_r))
        else $error("step-off acted with count one");

    a_protect_halt: assert property (@(posedge core_clk) disable iff (!rstn) // R13
        ce && sw_in.trim_protect_input && !seq_in.trimming
        |=> !run_enable)
        else $error("run not stopped by trim protect");

    a_home_accept: assert property (@(posedge core_clk) disable iff (!rstn) // R15
        ce && rise.home_return_input && !sw_in.home_inhibit_input
        |=> home_go)
        else $error("home request lost");

    a_thread_follow: assert property (@(posedge core_clk) disable iff (!rstn) // R16
        ce && ctrl_r[`CSL_CTRL_THS_BIT] && sw_in.needle_thread_sensor_input
        |=> thread_break)
        else $error("thread break not reported");

endmodule
`default_nettype wire

// *** rtl/csl_consts.svh ***
// Constants for the clamp and input signal logic
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CSL_OFS_CTRL 4'h0
`define CSL_OFS_STATUS 4'h4
`define CSL_OFS_IRQ_STAT 4'h8
`define CSL_OFS_IRQ_MASK 4'hc

// ****************************************
// Control register fields
// ****************************************
`define CSL_CTRL_COUNT_LSB 0
`define CSL_CTRL_COUNT_MSB 2
`define CSL_CTRL_PN2_BIT 3
`define CSL_CTRL_PRIO_BIT 4
`define CSL_CTRL_THS_BIT 5
`define CSL_CTRL_RESET 6'h04

// ****************************************
// Status register fields
// ****************************************
`define CSL_STAT_CLAMP_LSB 0
`define CSL_STAT_PN_LSB 4
`define CSL_STAT_RUN_BIT 8

// ****************************************
// Interrupt bits
// ****************************************
`define CSL_IRQ_THREAD 0
`define CSL_IRQ_HOME_REFUSED 1
`define CSL_IRQ_PROTECT_STOP 2
`define CSL_IRQ_RESET 3'h0

`endif

// *** rtl/csl_pkg.sv ***
// Types for the clamp and input signal logic
package csl_pkg;

    // Conditioned switch and sensor inputs
    typedef struct packed {
        logic clamp_step_on_input;
        logic clamp_step_off_input;
        logic clamp_clear_input;
        logic pneumatic_step_input;
        logic [3:0] clamp_toggle_inputs;
        logic [3:0] clamp_inhibit_inputs;
        logic all_clamp_inhibit_input;
        logic wiper_cancel_input;
        logic trim_cancel_input;
        logic trim_protect_input;
        logic home_inhibit_input;
        logic home_return_input;
        logic home_key_input;
        logic needle_thread_sensor_input;
    } csl_sw_t;

    // Requests from the sewing sequencer
    typedef struct packed {
        logic trim_req;
        logic release_req;
        logic wiper_req;
        logic running;
        logic trimming;
    } csl_seq_t;

    // Actuator outputs
    typedef struct packed {
        logic [3:0] clamp_outputs;
        logic pneumatic_low_output;
        logic pneumatic_high_output;
        logic pneumatic_third_output;
        logic trim_output;
        logic release_output;
        logic wiper_output;
    } csl_act_t;

    // Pneumatic three-step clamp states
    typedef enum logic [3:0] {
        CSL_PN_IDLE = 4'b0001,
        CSL_PN_LOW = 4'b0010,
        CSL_PN_HIGH = 4'b0100,
        CSL_PN_THIRD = 4'b1000
    } csl_pn_state_t;

endpackage

// *** sim/csl_panel_model.sv ***
// Operator switch, sensor and sequencer model driving the clamp logic
`timescale 1ns/1ps
`default_nettype none

module csl_panel_model (
    // Clock
    input wire logic core_clk,
    // Switch levels and sequencer requests towards the block
    output var csl_pkg::csl_sw_t sw,
    output var csl_pkg::csl_seq_t seq
);
    // ****************************************
    // Switch and sequencer drivers
    // ****************************************
    initial begin
        sw = '0;
        seq = '0;
    end

    // Press switches for hold cycles, then release and let the block settle
    task automatic press(input csl_pkg::csl_sw_t bits, input int hold);
        @(posedge core_clk);
        sw <= sw | bits;
        repeat (hold) @(posedge core_clk);
        sw <= sw & ~bits;
        repeat (2) @(posedge core_clk);
    endtask

    // Hold switches at a steady level
    task automatic level(input csl_pkg::csl_sw_t bits, input logic on);
        @(posedge core_clk);
        sw <= on ? (sw | bits) : (sw & ~bits);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Sequencer requests and machine state
    task automatic set_seq(input csl_pkg::csl_seq_t v);
        @(posedge core_clk);
        seq <= v;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the clamp logic
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic run_enable;
    logic home_go;
    logic thread_break;
    logic irq;
    logic [31:0] rd_v;
    csl_pkg::csl_sw_t sw;
    csl_pkg::csl_sw_t s;
    csl_pkg::csl_seq_t seq;
    csl_pkg::csl_seq_t q;
    csl_pkg::csl_act_t act;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int home_cnt = 0;

    always #5 core_clk = ~core_clk;

    csl_panel_model u_panel (.core_clk(core_clk), .sw(sw), .seq(seq));

    csl_clamp_logic dut (
        .core_clk(core_clk), .rstn(rstn), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sw_in(sw), .seq_in(seq), .act_out(act), .run_enable(run_enable),
        .home_go(home_go), .thread_break(thread_break), .irq(irq)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    always @(posedge core_clk) begin
        if (home_go === 1'b1) begin
            home_cnt <= home_cnt + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd_v = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic tog(input int i, input logic [3:0] exp);
        csl_pkg::csl_sw_t b;
        b = '0;
        b.clamp_toggle_inputs[i] = 1'b1;
        u_panel.press(b, 2);
        @(negedge core_clk);
        check(32'(act.clamp_outputs), 32'(exp));
    endtask

    task automatic step(input logic up, input logic [3:0] exp);
        csl_pkg::csl_sw_t b;
        b = '0;
        b.clamp_step_on_input = up;
        b.clamp_step_off_input = !up;
        u_panel.press(b, 4);
        @(negedge core_clk);
        check(32'(act.clamp_outputs), 32'(exp));
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check(32'(act), 32'h0);
        check({30'h0, run_enable, irq}, 32'h2);
        wb(1'b0, 4'h0, 32'h0);
        check(rd_v, 32'h4);
        wb(1'b0, 4'h2, 32'h0);
        check(rd_v, 32'h0);
        wb(1'b0, 4'hc, 32'h0);
        check(rd_v, 32'h0);
    endtask

    task automatic t_steps();
        for (int i = 1; i <= 5; i++) begin
            step(1'b1, (i > 4) ? 4'hf : 4'((1 << i) - 1));
        end
        for (int i = 1; i <= 4; i++) begin
            step(1'b0, 4'hf >> i);
        end
        wb(1'b1, 4'h0, 32'h1);
        step(1'b1, 4'h0);
        tog(0, 4'h1);
        step(1'b0, 4'h1);
        wb(1'b1, 4'h0, 32'h4);
        step(1'b1, 4'h3);
        tog(3, 4'hb);
        s = '0;
        s.clamp_clear_input = 1'b1;
        u_panel.press(s, 1);
        @(negedge core_clk);
        check(32'(act.clamp_outputs), 32'h0);
    endtask

    task automatic t_toggle();
        logic [3:0] e;
        e = 4'h0;
        for (int i = 0; i < 8; i++) begin
            e[i % 4] = !e[i % 4];
            tog(i % 4, e);
        end
        for (int i = 0; i < 4; i++) begin
            s = '0;
            s.clamp_inhibit_inputs[i] = 1'b1;
            u_panel.level(s, 1'b1);
            tog(i, 4'h0);
            u_panel.level(s, 1'b0);
        end
        s = '0;
        s.all_clamp_inhibit_input = 1'b1;
        u_panel.level(s, 1'b1);
        step(1'b1, 4'h0);
        tog(2, 4'h0);
        u_panel.level(s, 1'b0);
        wb(1'b1, 4'h0, 32'h14);
        tog(1, 4'h0);
        tog(0, 4'h1);
        tog(1, 4'h3);
        tog(3, 4'h3);
        tog(2, 4'h7);
        @(posedge core_clk);
        ce <= 1'b0;
        tog(3, 4'h7);
        @(posedge core_clk);
        ce <= 1'b1;
        wb(1'b1, 4'h0, 32'h4);
    endtask

    task automatic t_pneu();
        logic [2:0] e [4] = '{3'b100, 3'b010, 3'b001, 3'b100};
        s = '0;
        s.pneumatic_step_input = 1'b1;
        u_panel.press(s, 2);
        @(negedge core_clk);
        check(32'(act[5:3]), 32'h0);
        wb(1'b1, 4'h0, 32'hc);
        for (int i = 0; i < 4; i++) begin
            u_panel.press(s, 2);
            @(negedge core_clk);
            check(32'(act[5:3]), 32'(e[i]));
        end
        wb(1'b0, 4'h4, 32'h0);
        check(rd_v, 32'h127);
    endtask

    task automatic t_trim();
        q = '0;
        q.trim_req = 1'b1;
        q.release_req = 1'b1;
        q.wiper_req = 1'b1;
        u_panel.set_seq(q);
        check(32'(act[2:0]), 32'h7);
        s = '0;
        s.wiper_cancel_input = 1'b1;
        u_panel.level(s, 1'b1);
        check(32'(act[2:0]), 32'h6);
        s.trim_cancel_input = 1'b1;
        u_panel.level(s, 1'b1);
        check(32'(act[2:0]), 32'h0);
        u_panel.level(s, 1'b0);
        s = '0;
        s.trim_protect_input = 1'b1;
        q = '0;
        q.running = 1'b1;
        u_panel.set_seq(q);
        u_panel.level(s, 1'b1);
        check(32'(run_enable), 32'h0);
        u_panel.level(s, 1'b0);
        check(32'(run_enable), 32'h1);
        q.trimming = 1'b1;
        u_panel.set_seq(q);
        u_panel.level(s, 1'b1);
        check(32'(run_enable), 32'h1);
        q.trimming = 1'b0;
        u_panel.set_seq(q);
        check(32'(run_enable), 32'h0);
        u_panel.level(s, 1'b0);
    endtask

    task automatic t_home();
        int c;
        wb(1'b1, 4'hc, 32'h2);
        check(32'(irq), 32'h0);
        s = '0;
        s.home_inhibit_input = 1'b1;
        u_panel.level(s, 1'b1);
        c = home_cnt;
        s = '0;
        s.home_return_input = 1'b1;
        s.home_key_input = 1'b1;
        u_panel.press(s, 1);
        @(negedge core_clk);
        check(32'(home_cnt - c), 32'h0);
        check(32'(irq), 32'h1);
        wb(1'b0, 4'h8, 32'h0);
        check(32'(rd_v[1]), 32'h1);
        wb(1'b1, 4'h8, 32'h2);
        check(32'(irq), 32'h0);
        s = '0;
        s.home_inhibit_input = 1'b1;
        u_panel.level(s, 1'b0);
        s = '0;
        s.home_return_input = 1'b1;
        u_panel.press(s, 1);
        @(negedge core_clk);
        check(32'(home_cnt - c), 32'h1);
        s = '0;
        s.needle_thread_sensor_input = 1'b1;
        u_panel.level(s, 1'b1);
        check(32'(thread_break), 32'h0);
        wb(1'b1, 4'h0, 32'h24);
        @(negedge core_clk);
        check(32'(thread_break), 32'h1);
        wb(1'b0, 4'h8, 32'h0);
        check(rd_v, 32'h5);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        t_reset();
        t_steps();
        t_toggle();
        t_pneu();
        t_trim();
        t_home();
        end_of_test();
    end
endmodule

`default_nettype wire
